// ===== core/acc_pkg.sv
// Constants for the converter configuration and alert control block.
// Operation
// - Gain codes 110 and 111 equal 101.
// - Bit 8: continuous or single-shot, reset one.
// - Rate field 7:5 selects eight rates, reset 100.
// - Bit 4: hysteresis or window comparator.
// - Bit 3 sets alert pin polarity.
// - Continuous ready follows polarity bit directly.
// - Single-shot ready uses inverted polarity sense.
// - Unlatched alert clears when result in range (window) or below lower (hysteresis).
// - Latched alert holds until result read/response.
// - Alert response sends own address.
// - Queue code 11 disables comparator, floats pin.
// - Queue codes need one, two, four conversions.
// - Start bit begins one conversion when idle.
// - Threshold sign pattern makes pin ready output.
package acc_pkg;

  // ----------------------------------------------------------------
  // Register pointers and reset values.
  // ----------------------------------------------------------------
  localparam logic [1:0] PTR_RESULT = 2'h0;
  localparam logic [1:0] PTR_CONFIG = 2'h1;
  localparam logic [1:0] PTR_LOWER = 2'h2;
  localparam logic [1:0] PTR_UPPER = 2'h3;
  localparam logic [15:0] CFG_RESET = 16'h8583;
  localparam logic [15:0] LOWER_RESET = 16'h8000;
  localparam logic [15:0] UPPER_RESET = 16'h7fff;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Configuration field positions.
  // ----------------------------------------------------------------
  localparam int BIT_START = 15;
  localparam int MUX_HI = 14;
  localparam int MUX_LO = 12;
  localparam int GAIN_HI = 11;
  localparam int GAIN_LO = 9;
  localparam int BIT_MODE = 8;
  localparam int RATE_HI = 7;
  localparam int RATE_LO = 5;
  localparam int BIT_CTYPE = 4;
  localparam int BIT_POL = 3;
  localparam int BIT_LATCH = 2;
  localparam int QUE_HI = 1;
  localparam int QUE_LO = 0;

  // ----------------------------------------------------------------
  // Field codes.
  // ----------------------------------------------------------------
  localparam logic [2:0] GAIN_SMALLEST = 3'h5;
  localparam logic [1:0] QUE_ONE = 2'h0;
  localparam logic [1:0] QUE_TWO = 2'h1;
  localparam logic [1:0] QUE_FOUR = 2'h2;
  localparam logic [1:0] QUE_OFF = 2'h3;
  localparam logic [2:0] NEED_ONE = 3'h1;
  localparam logic [2:0] NEED_TWO = 3'h2;
  localparam logic [2:0] NEED_FOUR = 3'h4;

  // ----------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int RDY_PULSE_NS = 1000;
  localparam int RDY_PULSE_CYC =
    (RDY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] RDY_PULSE_LAST = 7'(RDY_PULSE_CYC - 1);

endpackage : acc_pkg

// ===== core/acc_cmp_if.sv
// Signals between the register core and the alert comparator engine.
`timescale 1ns/100ps
interface acc_cmp_if;
  logic result_valid;
  logic [15:0] result;
  logic [15:0] upper_threshold;
  logic [15:0] lower_threshold;
  logic window_mode;
  logic alert_latch_enable;
  logic [1:0] alert_queue_select;
  logic latch_clear;
  logic alert_active;

  modport eng (
    input result_valid, result, upper_threshold, lower_threshold,
    input window_mode, alert_latch_enable, alert_queue_select,
    input latch_clear,
    output alert_active
  );
  modport ctl (
    output result_valid, result, upper_threshold, lower_threshold,
    output window_mode, alert_latch_enable, alert_queue_select,
    output latch_clear,
    input alert_active
  );
endinterface : acc_cmp_if

// ===== core/acc_alert_engine.sv
// Digital threshold comparator with queue count and optional latch.
`timescale 1ns/100ps
module acc_alert_engine (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  acc_cmp_if.eng cmp
);

  logic [2:0] count_reg;
  logic [2:0] count_next;
  logic alert_reg;
  logic alert_next;
  logic above;
  logic below;
  logic beyond;
  logic [2:0] need;
  logic [2:0] count_inc;

  // ----------------------------------------------------------------
  // Compare and count.
  // ----------------------------------------------------------------

  // Thresholds and results are twos complement, so compare signed.
  always_comb begin
    above = $signed(cmp.result) > $signed(cmp.upper_threshold);
    below = $signed(cmp.result) < $signed(cmp.lower_threshold);
    beyond = cmp.window_mode ? (above | below) : above;
    case (cmp.alert_queue_select)
      acc_pkg::QUE_ONE: need = acc_pkg::NEED_ONE;
      acc_pkg::QUE_TWO: need = acc_pkg::NEED_TWO;
      acc_pkg::QUE_FOUR: need = acc_pkg::NEED_FOUR;
      default: need = acc_pkg::NEED_FOUR;
    endcase
    count_inc = (count_reg < need) ? count_reg + 3'h1 : count_reg;
  end

  // Next count and alert state; a fresh trip beats a latch clear.
  always_comb begin
    count_next = count_reg;
    alert_next = alert_reg;
    if (cmp.alert_queue_select == acc_pkg::QUE_OFF) begin
      count_next = 3'h0;
      alert_next = 1'b0;
    end else begin
      if (cmp.latch_clear && cmp.alert_latch_enable) begin
        alert_next = 1'b0;
      end
      if (cmp.result_valid) begin
        if (beyond) begin
          count_next = count_inc;
          if (count_inc >= need) begin
            alert_next = 1'b1;
          end
        end else begin
          count_next = 3'h0;
          // Unlatched release: hysteresis waits for a drop below lower.
          if (!cmp.alert_latch_enable &&
              (cmp.window_mode || below)) begin
            alert_next = 1'b0;
          end
        end
      end
    end
  end

  // Register the engine state.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      count_reg <= 3'h0;
      alert_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      alert_reg <= alert_next;
    end
  end

  assign cmp.alert_active = alert_reg;

endmodule : acc_alert_engine

// ===== core/acc_config_top.sv
// Configuration register, conversion control and alert/ready pin logic.
`timescale 1ns/100ps
module acc_config_top #(
  parameter logic [6:0] DEV_ADDR = 7'h10 // Arbitrary bus address.
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] reg_ptr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  input wire logic alert_resp_i,
  output logic alert_resp_ack_o,
  output logic [6:0] alert_resp_addr_o,
  output logic conv_start_o,
  input wire logic conv_done_i,
  input wire logic [15:0] conv_data_i,
  output logic [2:0] mux_sel_o,
  output logic [2:0] full_scale_range_o,
  output logic [2:0] data_rate_select_o,
  output logic alert_o,
  output logic alert_oe_o
);

  typedef enum logic {
    ACC_IDLE,
    ACC_BUSY
  } acc_state_t;

  acc_cmp_if cmp ();

  logic [14:0] cfg_reg;
  logic [14:0] cfg_next;
  logic [15:0] lower_reg;
  logic [15:0] lower_next;
  logic [15:0] upper_reg;
  logic [15:0] upper_next;
  logic [15:0] result_reg;
  logic [15:0] result_next;
  acc_state_t state_reg;
  acc_state_t state_next;
  logic start_reg;
  logic start_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic ack_reg;
  logic ack_next;
  logic [6:0] pulse_reg;
  logic [6:0] pulse_next;
  logic pulse_on_reg;
  logic pulse_on_next;
  logic pin_reg;
  logic pin_next;
  logic oe_reg;
  logic oe_next;
  logic [2:0] gain_reg;
  logic [2:0] gain_next;
  logic single_mode;
  logic polarity;
  logic ready_mode;
  logic cfg_write;
  logic busy;

  // ----------------------------------------------------------------
  // Decoded configuration.
  // ----------------------------------------------------------------

  // Ready function is chosen by the threshold sign bits alone.
  always_comb begin
    single_mode = cfg_reg[acc_pkg::BIT_MODE];
    polarity = cfg_reg[acc_pkg::BIT_POL];
    ready_mode = upper_reg[15] & ~lower_reg[15];
    cfg_write = reg_wr_i && (reg_ptr_i == acc_pkg::PTR_CONFIG);
    busy = (state_reg == ACC_BUSY);
  end

  // ----------------------------------------------------------------
  // Register file.
  // ----------------------------------------------------------------

  // Host writes; the result register is loaded only by the converter.
  always_comb begin
    cfg_next = cfg_reg;
    lower_next = lower_reg;
    upper_next = upper_reg;
    result_next = result_reg;
    if (reg_wr_i) begin
      case (reg_ptr_i)
        acc_pkg::PTR_CONFIG: cfg_next = reg_wdata_i[14:0];
        acc_pkg::PTR_LOWER: lower_next = reg_wdata_i;
        acc_pkg::PTR_UPPER: upper_next = reg_wdata_i;
        default: cfg_next = cfg_reg;
      endcase
    end
    if (busy && conv_done_i) begin
      result_next = conv_data_i;
    end
  end

  // Read data returns one cycle after the read strobe.
  always_comb begin
    case (reg_ptr_i)
      acc_pkg::PTR_RESULT: rdata_next = result_reg;
      acc_pkg::PTR_CONFIG: rdata_next = {~busy, cfg_reg};
      acc_pkg::PTR_LOWER: rdata_next = lower_reg;
      acc_pkg::PTR_UPPER: rdata_next = upper_reg;
      default: rdata_next = 16'h0000;
    endcase
    if (!reg_rd_i) begin
      rdata_next = rdata_reg;
    end
  end

  // Gain codes beyond the smallest range fold onto it.
  always_comb begin
    gain_next = cfg_next[acc_pkg::GAIN_HI:acc_pkg::GAIN_LO];
    if (gain_next > acc_pkg::GAIN_SMALLEST) begin
      gain_next = acc_pkg::GAIN_SMALLEST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_reg <= acc_pkg::CFG_RESET[14:0];
      lower_reg <= acc_pkg::LOWER_RESET;
      upper_reg <= acc_pkg::UPPER_RESET;
      result_reg <= acc_pkg::RESULT_RESET;
      rdata_reg <= 16'h0000;
      gain_reg <= acc_pkg::CFG_RESET[acc_pkg::GAIN_HI:acc_pkg::GAIN_LO];
    end else begin
      cfg_reg <= cfg_next;
      lower_reg <= lower_next;
      upper_reg <= upper_next;
      result_reg <= result_next;
      rdata_reg <= rdata_next;
      gain_reg <= gain_next;
    end
  end

  // ----------------------------------------------------------------
  // Conversion control.
  // ----------------------------------------------------------------

  // Single-shot starts only from idle; a write during a conversion is
  // dropped rather than queued, matching the status bit semantics.
  always_comb begin
    state_next = state_reg;
    start_next = 1'b0;
    case (state_reg)
      ACC_IDLE: begin
        if (!single_mode) begin
          start_next = 1'b1;
          state_next = ACC_BUSY;
        end else if (cfg_write && reg_wdata_i[acc_pkg::BIT_START]) begin
          start_next = 1'b1;
          state_next = ACC_BUSY;
        end
      end
      ACC_BUSY: begin
        if (conv_done_i) begin
          state_next = ACC_IDLE;
        end
      end
      default: state_next = ACC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= ACC_IDLE;
      start_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      start_reg <= start_next;
    end
  end

  // ----------------------------------------------------------------
  // Comparator engine hookup.
  // ----------------------------------------------------------------

  // A result read or an alert response releases a latched alert.
  always_comb begin
    cmp.result_valid = busy && conv_done_i;
    cmp.result = conv_data_i;
    cmp.upper_threshold = upper_reg;
    cmp.lower_threshold = lower_reg;
    cmp.window_mode = cfg_reg[acc_pkg::BIT_CTYPE];
    cmp.alert_latch_enable = cfg_reg[acc_pkg::BIT_LATCH];
    cmp.alert_queue_select = cfg_reg[acc_pkg::QUE_HI:acc_pkg::QUE_LO];
    cmp.latch_clear = (reg_rd_i && reg_ptr_i == acc_pkg::PTR_RESULT) ||
                      ack_next;
  end

  acc_alert_engine u_engine (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .cmp(cmp.eng)
  );

  // ----------------------------------------------------------------
  // Alert response and pin drive.
  // ----------------------------------------------------------------

  // Only a latched, asserted alert answers the response; bus-level
  // arbitration toward the lowest address happens on the wire.
  always_comb begin
    ack_next = alert_resp_i && cmp.alert_latch_enable &&
               cmp.alert_active && !ready_mode;
  end

  // Continuous ready pulse lasts a fixed count after each result.
  always_comb begin
    pulse_next = pulse_reg;
    pulse_on_next = pulse_on_reg;
    if (busy && conv_done_i && !single_mode) begin
      pulse_on_next = 1'b1;
      pulse_next = 7'h00;
    end else if (pulse_on_reg) begin
      if (pulse_reg == acc_pkg::RDY_PULSE_LAST) begin
        pulse_on_next = 1'b0;
      end else begin
        pulse_next = pulse_reg + 7'h01;
      end
    end
  end

  // Pin level: active level is the polarity bit, except single-shot
  // ready which mirrors the idle status with the sense inverted.
  always_comb begin
    oe_next = cmp.alert_queue_select != acc_pkg::QUE_OFF;
    if (!ready_mode) begin
      pin_next = cmp.alert_active ? polarity : ~polarity;
    end else if (single_mode) begin
      pin_next = (state_next == ACC_IDLE) ^ polarity;
    end else begin
      pin_next = pulse_on_next ? polarity : ~polarity;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ack_reg <= 1'b0;
      pulse_reg <= 7'h00;
      pulse_on_reg <= 1'b0;
      pin_reg <= 1'b1;
      oe_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
      pulse_reg <= pulse_next;
      pulse_on_reg <= pulse_on_next;
      pin_reg <= pin_next;
      oe_reg <= oe_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------
  assign reg_rdata_o = rdata_reg;
  assign alert_resp_ack_o = ack_reg;
  assign alert_resp_addr_o = DEV_ADDR;
  assign conv_start_o = start_reg;
  assign mux_sel_o = cfg_reg[acc_pkg::MUX_HI:acc_pkg::MUX_LO];
  assign full_scale_range_o = gain_reg;
  assign data_rate_select_o =
    cfg_reg[acc_pkg::RATE_HI:acc_pkg::RATE_LO];
  assign alert_o = pin_reg;
  assign alert_oe_o = oe_reg;

endmodule : acc_config_top

// ===== bench/acc_config_properties.sv
// Port-level assertions for the configuration and alert block.
`timescale 1ns/100ps
module acc_config_properties #(
  parameter logic [6:0] DEV_ADDR = 7'h10
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] reg_ptr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic alert_resp_i,
  input wire logic alert_resp_ack_o,
  input wire logic [6:0] alert_resp_addr_o,
  input wire logic conv_start_o,
  input wire logic conv_done_i,
  input wire logic [2:0] full_scale_range_o,
  input wire logic [2:0] data_rate_select_o,
  input wire logic alert_o,
  input wire logic alert_oe_o
);
  logic [15:0] cfg_reg;
  logic [15:0] cfg_next;
  logic busy_reg;
  logic busy_next;
  logic busy_h;
  logic cfg_wr;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Shadow of the stored word; the start pulse counts as busy at once.
  assign cfg_wr = reg_wr_i && reg_ptr_i == acc_pkg::PTR_CONFIG;
  assign busy_h = busy_reg | conv_start_o;
  always_comb begin
    cfg_next = cfg_wr ? reg_wdata_i : cfg_reg;
    busy_next = conv_start_o | (busy_reg & ~conv_done_i);
  end
  always_ff @(posedge clk_i) begin
    cfg_reg <= sys_rst_i ? acc_pkg::CFG_RESET : cfg_next;
    busy_reg <= sys_rst_i ? 1'b0 : busy_next;
  end
  property p_oe_off;
    cfg_reg[1:0] == acc_pkg::QUE_OFF [*3] |-> !alert_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin driven");
  property p_rate;
    !reg_wr_i [*3] |-> data_rate_select_o == cfg_reg[7:5];
  endproperty
  a_rate: assert property (p_rate) else $error("rate wrong");
  property p_fsr;
    !reg_wr_i [*3] |-> full_scale_range_o == ((cfg_reg[11:9] > 3'h5) ?
      acc_pkg::GAIN_SMALLEST : cfg_reg[11:9]);
  endproperty
  a_fsr: assert property (p_fsr) else $error("range wrong");
  property p_start;
    cfg_wr && reg_wdata_i[15] && reg_wdata_i[8] && cfg_reg[8] && !busy_h
      |=> conv_start_o;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_no_start;
    busy_h && !conv_done_i |=> !conv_start_o;
  endproperty
  a_no_start: assert property (p_no_start) else $error("start");
  property p_status;
    reg_rd_i && reg_ptr_i == acc_pkg::PTR_CONFIG
      |=> reg_rdata_o == {!$past(busy_h), $past(cfg_reg[14:0])};
  endproperty
  a_status: assert property (p_status) else $error("status");
  property p_ack_src;
    alert_resp_ack_o |-> $past(alert_resp_i) && $past(cfg_reg[2]);
  endproperty
  a_ack_src: assert property (p_ack_src) else $error("ack");
  property p_addr;
    alert_resp_addr_o == DEV_ADDR;
  endproperty
  a_addr: assert property (p_addr) else $error("address");
  property p_ack_clear;
    alert_resp_ack_o && !$past(conv_done_i) && !$past(conv_done_i, 2)
      |-> ##[1:2] alert_o == !cfg_reg[3];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("held");
  c_start: cover property (conv_start_o);
  c_ack: cover property (alert_resp_ack_o);
  c_drive: cover property (alert_oe_o && !alert_o);
endmodule : acc_config_properties

// ===== bench/acc_conv_model.sv
// Behavioural converter answering each start with one result.
`timescale 1ns/100ps
module acc_conv_model #(
  parameter int DLY = 8
) (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [15:0] value_i,
  output logic done_o,
  output logic [15:0] data_o
);
  int cnt;
  initial begin
    done_o = 1'b0;
    data_o = 16'hffff;
    cnt = 0;
  end
  // One conversion at a time; data toggles when not valid.
  always @(negedge clk_i) begin
    done_o <= 1'b0;
    data_o <= ~data_o;
    if (start_i) cnt <= DLY;
    else if (cnt == 1) begin
      done_o <= 1'b1;
      data_o <= value_i;
      cnt <= 0;
    end else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule : acc_conv_model

// ===== bench/adc_config_alert_control_tb_top.sv
// Self-checking bench for the configuration and alert block.
`timescale 1ns/100ps
module adc_config_alert_control_tb_top;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] ptr = 2'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic resp = 1'b0;
  logic [15:0] conv_val = 16'h0000;
  logic [15:0] rdata;
  logic ack;
  logic [6:0] addr;
  logic start;
  logic done;
  logic [15:0] cdata;
  logic [2:0] full_scale_range;
  logic [2:0] mux;
  logic [2:0] rate;
  logic alert;
  logic oe;
  logic [15:0] c;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #12.5 clk_i = ~clk_i;
  acc_config_top dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_ptr_i(ptr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .alert_resp_i(resp), .alert_resp_ack_o(ack),
    .alert_resp_addr_o(addr), .conv_start_o(start), .conv_done_i(done),
    .conv_data_i(cdata), .mux_sel_o(mux), .full_scale_range_o(full_scale_range),
    .data_rate_select_o(rate), .alert_o(alert), .alert_oe_o(oe));
  acc_conv_model #(.DLY(8)) conv_u (.clk_i(clk_i), .start_i(start),
    .value_i(conv_val), .done_o(done), .data_o(cdata));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr_reg(input logic [1:0] p, input logic [15:0] d);
    @(negedge clk_i);
    {wr, ptr, wdata} = {1'b1, p, d};
    @(negedge clk_i);
    wr = 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [1:0] p, input logic [15:0] exp);
    @(negedge clk_i);
    {rd, ptr} = {1'b1, p};
    @(negedge clk_i);
    rd = 1'b0;
    chk(rdata, exp);
  endtask : rd_reg
  // Bounded wait for a result, then time for the pin to settle.
  task wait_done;
    int k;
    k = 0;
    @(posedge clk_i);
    while (done !== 1'b1 && k < 200) begin
      @(posedge clk_i);
      k++;
    end
    if (k == 200) chk(16'hdead, 16'h0000);
    repeat (3) @(negedge clk_i);
  endtask : wait_done
  task cv(input logic [15:0] cw, input logic [15:0] d);
    conv_val = d;
    wr_reg(2'h1, cw | 16'h8000);
    wait_done();
  endtask : cv
  function automatic logic [15:0] f(input logic m, input logic t,
      input logic p, input logic l, input logic [1:0] q);
    return {4'h0, 3'h2, m, 3'h4, t, p, l, q};
  endfunction : f
  task results;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  // Watchdog sized well above the expected run length.
  initial begin
    #(25 * 30000);
    n_mismatch++;
    results();
  end
  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(negedge clk_i);
    sys_rst_i = 1'b0;
    rd_reg(2'h1, 16'h8583);
    rd_reg(2'h2, 16'h8000);
    rd_reg(2'h3, 16'h7fff);
    chk({15'h0, oe}, 16'h0000);
    wr_reg(2'h0, 16'h1234);
    rd_reg(2'h0, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      wr_reg(2'h1, {1'b0, 3'(i), 3'(i), 1'b1, 3'(i), 5'h03});
      repeat (3) @(negedge clk_i);
      chk({13'h0, full_scale_range}, (i > 5) ? 16'h0005 : 16'(i));
      chk({10'h0, mux, rate}, {10'h0, 3'(i), 3'(i)});
    end
    wr_reg(2'h2, 16'h0100);
    wr_reg(2'h3, 16'h0200);
    for (int q = 0; q < 3; q++) begin
      c = f(1'b1, 1'b0, 1'b0, 1'b0, 2'(q));
      cv(c, 16'h0050);
      cv(c, 16'h0150);
      chk({15'h0, oe}, 16'h0001);
      for (int i = 1; i <= (1 << q); i++) begin
        cv(c, 16'h0300);
        chk({15'h0, alert}, {15'h0, i < (1 << q)});
      end
      cv(c, 16'h0150);
      chk({15'h0, alert}, 16'h0000);
      cv(c, 16'h0050);
      chk({15'h0, alert}, 16'h0001);
    end
    rd_reg(2'h0, 16'h0050);
    c = f(1'b1, 1'b0, 1'b1, 1'b0, 2'h0);
    cv(c, 16'h0300);
    chk({15'h0, alert}, 16'h0001);
    c = f(1'b1, 1'b1, 1'b0, 1'b0, 2'h0);
    cv(c, 16'h0050);
    chk({15'h0, alert}, 16'h0000);
    cv(c, 16'h0150);
    chk({15'h0, alert}, 16'h0001);
    c = f(1'b1, 1'b0, 1'b0, 1'b1, 2'h0);
    cv(c, 16'h0300);
    cv(c, 16'h0050);
    chk({15'h0, alert}, 16'h0000);
    rd_reg(2'h0, 16'h0050);
    repeat (2) @(negedge clk_i);
    chk({15'h0, alert}, 16'h0001);
    cv(c, 16'h0300);
    @(negedge clk_i);
    resp = 1'b1;
    @(negedge clk_i);
    resp = 1'b0;
    chk({8'h0, ack, addr}, 16'h0090);
    repeat (2) @(negedge clk_i);
    chk({15'h0, alert}, 16'h0001);
    wr_reg(2'h2, 16'h0000);
    wr_reg(2'h3, 16'h8000);
    c = f(1'b1, 1'b0, 1'b0, 1'b0, 2'h0);
    wr_reg(2'h1, c);
    repeat (3) @(negedge clk_i);
    chk({15'h0, alert}, 16'h0001);
    conv_val = 16'h0042;
    wr_reg(2'h1, c | 16'h8000);
    repeat (2) @(negedge clk_i);
    chk({15'h0, alert}, 16'h0000);
    rd_reg(2'h1, c);
    wait_done();
    rd_reg(2'h1, c | 16'h8000);
    rd_reg(2'h0, 16'h0042);
    wr_reg(2'h1, f(1'b1, 1'b0, 1'b1, 1'b0, 2'h0));
    repeat (3) @(negedge clk_i);
    chk({15'h0, alert}, 16'h0000);
    for (int p = 0; p < 2; p++) begin
      wr_reg(2'h1, f(1'b0, 1'b0, 1'(p), 1'b0, 2'h0));
      wait_done();
      chk({15'h0, alert}, 16'(p));
    end
    wr_reg(2'h1, f(1'b1, 1'b0, 1'b0, 1'b0, 2'h3));
    repeat (4) @(negedge clk_i);
    chk({15'h0, oe}, 16'h0000);
    results();
  end
endmodule : adc_config_alert_control_tb_top
bind acc_config_top acc_config_properties #(.DEV_ADDR(DEV_ADDR)) chk_u (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_ptr_i(reg_ptr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .alert_resp_i(alert_resp_i),
  .alert_resp_ack_o(alert_resp_ack_o),
  .alert_resp_addr_o(alert_resp_addr_o), .conv_start_o(conv_start_o),
  .conv_done_i(conv_done_i), .full_scale_range_o(full_scale_range_o),
  .data_rate_select_o(data_rate_select_o), .alert_o(alert_o),
  .alert_oe_o(alert_oe_o));
